// [trig_pkg.sv]
// Shared constants, field layout and types of the bus monitor trigger unit
// ****************************************************************************
// How it works
// - Two trigger sequences run at once; their outcomes steer capture start and stop.
// - Storage holds up to 254 control blocks, each selectable later.
// - Block kind: 0 error condition, 1 external event, 2 received word, 3 data value.
// - Active block with strobe flag set pulses the trigger strobe output when met.
// - Active block with interrupt flag set raises an interrupt carrying its number; if both sequences fire at once, sequence 0's number is carried.
// - A met block clears status pattern bits chosen by its clear field.
// - A met block sets status pattern bits chosen by its set field.
// - A sequence steps through chained blocks to detect ordered bus events.
// - A static trigger is one error or external block that never advances.
// - External block fires on a pulse seen on the trigger input pin.
// - Error block fires when any one of its selected errors occurs.
// - Error bits 14..8: bus reply, few words, extra words, exception, address, gap, command.
// - Error bits 7..0: dual send, spacing, sync, parity, few bits, extra bits, biphase, no reply.
// - Error bit 15 means any of error bits 14 through 0.
// - Data value blocks invert the range result when the flip flag is set.
// - Word and data blocks compare only the bits chosen by the match mask.
// - Data value blocks check the masked word within low and high, inclusive.
// - Word and data blocks name a successor and an end of message successor.
// - Error blocks keep their error selection in the match word.
// - Status exception check uses a mask that resets to 0x07FF.
// ****************************************************************************
package trig_pkg;
   localparam int NUM_SEQ = 2;
   localparam int NUM_CB = 254;
   localparam int CB_IDX_W = 8;
   localparam int STAT_W = 8;
   localparam logic [CB_IDX_W-1:0] CB_NONE = 8'hFF;
   // Block kinds
   localparam logic [1:0] KIND_ERROR = 2'h0;
   localparam logic [1:0] KIND_EXTERNAL = 2'h1;
   localparam logic [1:0] KIND_WORD = 2'h2;
   localparam logic [1:0] KIND_VALUE = 2'h3;
   // Error selection bits
   localparam int ERR_ANY_FAULT = 15;
   localparam int ERR_WRONG_BUS_REPLY = 14;
   localparam int ERR_FEW_WORDS = 13;
   localparam int ERR_EXTRA_WORDS = 12;
   localparam int ERR_REPLY_EXCEPTION = 11;
   localparam int ERR_ADDR_MISMATCH = 10;
   localparam int ERR_EARLY_GAP = 9;
   localparam int ERR_BAD_COMMAND = 8;
   localparam int ERR_DUAL_CHANNEL_SEND = 7;
   localparam int ERR_WORD_SPACING_FAULT = 6;
   localparam int ERR_FLIPPED_SYNC = 5;
   localparam int ERR_ODD_EVEN_FAULT = 4;
   localparam int ERR_FEW_BITS = 3;
   localparam int ERR_EXTRA_BITS = 2;
   localparam int ERR_BIPHASE_FAULT = 1;
   localparam int ERR_NO_REPLY = 0;
   localparam int STATUS_BITS_W = 11;
   localparam logic [STATUS_BITS_W-1:0] SWX_MASK_RESET = 11'h7FF;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SEQ_START = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_SWX_MASK = 8'h0C;
   localparam logic [7:0] ADDR_CB_W0 = 8'h10;
   localparam logic [7:0] ADDR_CB_W1 = 8'h14;
   localparam logic [7:0] ADDR_CB_W2 = 8'h18;
   localparam logic [7:0] ADDR_CB_W3 = 8'h1C;
   localparam logic [7:0] ADDR_CB_COMMIT = 8'h20;
   localparam logic [7:0] ADDR_STATE = 8'h24;
   // Control block layout
   typedef struct packed {
      logic [1:0] trigger_kind;
      logic strobe_on_fire;
      logic irq_on_fire;
      logic flip_limit_result;
      logic [STAT_W-1:0] status_clear_bits;
      logic [STAT_W-1:0] status_assert_bits;
      logic [CB_IDX_W-1:0] next_block;
      logic [CB_IDX_W-1:0] eom_block;
      logic [15:0] match_word;
      logic [15:0] match_mask;
      logic [15:0] range_low;
      logic [15:0] range_high;
   } cb_type;
   localparam int CB_W = $bits(cb_type);
endpackage : trig_pkg

// [cb_store.sv]
// Control block memory with one write port and one registered read port per sequence
`timescale 1ns/1ps
module cb_store
   import trig_pkg::*;
#(
   parameter int DEPTH = NUM_CB,
   parameter int WIDTH = CB_W
) (
   // Clock
   input wire logic clk_sys_i,
   // Write port
   input wire logic wr_en_i,
   input wire logic [CB_IDX_W-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   // Read ports
   input wire logic [NUM_SEQ-1:0][CB_IDX_W-1:0] rd_addr_i,
   output logic [NUM_SEQ-1:0][WIDTH-1:0] rd_data_o
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_sys_i) begin
      if (wr_en_i && (32'(wr_addr_i) < DEPTH)) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      for (int s = 0; s < NUM_SEQ; s++) begin
         if (32'(rd_addr_i[s]) < DEPTH) begin
            rd_data_o[s] <= mem[rd_addr_i[s]];
         end else begin
            rd_data_o[s] <= '0;
         end
      end
   end
endmodule : cb_store

// [cb_match.sv]
// Condition check of one control block against the current bus event
`timescale 1ns/1ps
module cb_match
   import trig_pkg::*;
(
   // Clock and reset for checks
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Block
   input wire cb_type cb_i,
   input wire logic armed_i,
   // Events
   input wire logic word_valid_i,
   input wire logic [15:0] word_data_i,
   input wire logic word_is_status_i,
   input wire logic err_valid_i,
   input wire logic [ERR_ANY_FAULT-1:0] err_flags_i,
   input wire logic ext_pulse_i,
   input wire logic [STATUS_BITS_W-1:0] swx_mask_i,
   // Result
   output logic hit_o
);
   logic [15:0] errs;
   logic [15:0] masked;
   logic exception;
   logic in_range;

   always_comb begin
      exception = word_valid_i && word_is_status_i
                  && |(word_data_i[STATUS_BITS_W-1:0] & swx_mask_i);
      errs = {1'b0, err_flags_i & {ERR_ANY_FAULT{err_valid_i}}};
      errs[ERR_REPLY_EXCEPTION] = errs[ERR_REPLY_EXCEPTION] | exception;
      errs[ERR_ANY_FAULT] = |errs[ERR_ANY_FAULT-1:0];
      masked = word_data_i & cb_i.match_mask;
      in_range = (masked >= cb_i.range_low) && (masked <= cb_i.range_high);
      hit_o = 1'b0;
      if (armed_i) begin
         case (cb_i.trigger_kind)
            KIND_ERROR: hit_o = |(errs & cb_i.match_word);
            KIND_EXTERNAL: hit_o = ext_pulse_i;
            KIND_WORD: hit_o = word_valid_i
                               && ((word_data_i & cb_i.match_mask)
                                   == (cb_i.match_word & cb_i.match_mask));
            default: hit_o = word_valid_i && (in_range ^ cb_i.flip_limit_result);
         endcase
      end
   end

   AST_ERR_OR: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      armed_i && cb_i.trigger_kind == KIND_ERROR && err_valid_i
      && |(err_flags_i & cb_i.match_word[ERR_ANY_FAULT-1:0]) |-> hit_o)
      else $error("selected error did not fire");
   AST_ANY_FAULT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      armed_i && cb_i.trigger_kind == KIND_ERROR && cb_i.match_word[ERR_ANY_FAULT]
      && err_valid_i && |err_flags_i |-> hit_o)
      else $error("any fault selection did not fire");
   AST_RANGE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      armed_i && cb_i.trigger_kind == KIND_VALUE && word_valid_i
      |-> hit_o == (((word_data_i & cb_i.match_mask) >= cb_i.range_low
                     && (word_data_i & cb_i.match_mask) <= cb_i.range_high)
                    != cb_i.flip_limit_result))
      else $error("range check result wrong");
endmodule : cb_match

// [trig_unit.sv]
// Bus monitor trigger unit: APB registers, two trigger sequences and their actions
`timescale 1ns/1ps
module trig_unit
   import trig_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Decoded bus events
   input wire logic word_valid_i,
   input wire logic [15:0] word_data_i,
   input wire logic word_is_status_i,
   input wire logic word_eom_i,
   input wire logic err_valid_i,
   input wire logic [ERR_ANY_FAULT-1:0] err_flags_i,
   // Trigger pins
   input wire logic trig_pin_i,
   output logic trig_strobe_o,
   // Block interrupt and capture control
   output logic cb_irq_o,
   output logic [CB_IDX_W-1:0] cb_irq_num_o,
   output logic [STAT_W-1:0] status_pattern_o
);
   // ************************************************************************
   // Declarations
   // ************************************************************************
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [NUM_SEQ-1:0] seq_en_q;
   logic [NUM_SEQ-1:0][CB_IDX_W-1:0] ptr_q;
   logic [NUM_SEQ-1:0][CB_IDX_W-1:0] fetched_q;
   logic [NUM_SEQ-1:0][CB_W-1:0] rd_data;
   cb_type [NUM_SEQ-1:0] cb;
   logic [NUM_SEQ-1:0] armed;
   logic [NUM_SEQ-1:0] hit;
   logic [STAT_W-1:0] status_q;
   logic [STATUS_BITS_W-1:0] swx_mask_q;
   logic [3:0][31:0] stage_q;
   logic mem_wr_q;
   logic [2:0] pin_sync_q;
   logic ext_pulse;
   logic wr_acc;
   logic setup;
   logic commit;
   logic [STAT_W-1:0] clr_all;
   logic [STAT_W-1:0] set_all;
   logic strobe_q;
   logic irq_q;
   logic [CB_IDX_W-1:0] irq_num_q;

   function automatic logic advancing(input cb_type b);
      return b.trigger_kind == KIND_WORD || b.trigger_kind == KIND_VALUE;
   endfunction : advancing

   // ************************************************************************
   // APB slave
   // ************************************************************************
   assign setup = psel_i && !penable_i;
   assign wr_acc = psel_i && penable_i && pready_q && pwrite_i;
   assign commit = wr_acc && paddr_i == ADDR_CB_COMMIT;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= setup;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
         if (setup) begin
            if (paddr_i == ADDR_CTRL) begin
               prdata_q <= 32'(seq_en_q);
            end else if (paddr_i == ADDR_SEQ_START) begin
               prdata_q <= 32'({ptr_q[1], ptr_q[0]});
            end else if (paddr_i == ADDR_STATUS) begin
               prdata_q <= 32'(status_q);
            end else if (paddr_i == ADDR_SWX_MASK) begin
               prdata_q <= 32'(swx_mask_q);
            end else if (paddr_i == ADDR_CB_W0) begin
               prdata_q <= stage_q[0];
            end else if (paddr_i == ADDR_CB_W1) begin
               prdata_q <= stage_q[1];
            end else if (paddr_i == ADDR_CB_W2) begin
               prdata_q <= stage_q[2];
            end else if (paddr_i == ADDR_CB_W3) begin
               prdata_q <= stage_q[3];
            end else if (paddr_i == ADDR_CB_COMMIT) begin
               prdata_q <= '0;
            end else if (paddr_i == ADDR_STATE) begin
               prdata_q <= 32'({irq_num_q, ptr_q[1], ptr_q[0]});
            end else begin
               pslverr_q <= 1'b1;
            end
         end
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;

   // Configuration registers and block staging words
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         seq_en_q <= '0;
         swx_mask_q <= SWX_MASK_RESET;
         stage_q <= '0;
         mem_wr_q <= 1'b0;
      end else begin
         mem_wr_q <= commit;
         if (wr_acc && paddr_i == ADDR_CTRL) begin
            seq_en_q <= pwdata_i[NUM_SEQ-1:0];
         end
         if (wr_acc && paddr_i == ADDR_SWX_MASK) begin
            swx_mask_q <= pwdata_i[STATUS_BITS_W-1:0];
         end
         if (wr_acc && paddr_i == ADDR_CB_W0) begin
            stage_q[0] <= pwdata_i;
         end
         if (wr_acc && paddr_i == ADDR_CB_W1) begin
            stage_q[1] <= pwdata_i;
         end
         if (wr_acc && paddr_i == ADDR_CB_W2) begin
            stage_q[2] <= pwdata_i;
         end
         if (wr_acc && paddr_i == ADDR_CB_W3) begin
            stage_q[3] <= pwdata_i;
         end
      end
   end

   // ************************************************************************
   // Control block storage
   // ************************************************************************
   cb_store #(
      .DEPTH(NUM_CB),
      .WIDTH(CB_W)
   ) u_store (
      .clk_sys_i(clk_sys_i),
      .wr_en_i(commit),
      .wr_addr_i(pwdata_i[CB_IDX_W-1:0]),
      .wr_data_i(CB_W'({stage_q[0][20:0], stage_q[1][15:0], stage_q[2], stage_q[3]})),
      .rd_addr_i(ptr_q),
      .rd_data_o(rd_data)
   );

   // ************************************************************************
   // Trigger input pin
   // ************************************************************************
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_sync_q <= '0;
      end else begin
         pin_sync_q <= {pin_sync_q[1:0], trig_pin_i};
      end
   end

   assign ext_pulse = pin_sync_q[1] && !pin_sync_q[2];

   // ************************************************************************
   // Sequence evaluation
   // ************************************************************************
   for (genvar s = 0; s < NUM_SEQ; s++) begin : g_seq
      assign cb[s] = cb_type'(rd_data[s]);
      assign armed[s] = seq_en_q[s] && fetched_q[s] == ptr_q[s] && !mem_wr_q
                        && 32'(ptr_q[s]) < NUM_CB;
      cb_match u_match (
         .clk_sys_i(clk_sys_i),
         .rst_n_i(rst_n_i),
         .cb_i(cb[s]),
         .armed_i(armed[s]),
         .word_valid_i(word_valid_i),
         .word_data_i(word_data_i),
         .word_is_status_i(word_is_status_i),
         .err_valid_i(err_valid_i),
         .err_flags_i(err_flags_i),
         .ext_pulse_i(ext_pulse),
         .swx_mask_i(swx_mask_q),
         .hit_o(hit[s])
      );
   end

   // Block pointers step along the chain
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ptr_q <= {NUM_SEQ{CB_NONE}};
         fetched_q <= {NUM_SEQ{CB_NONE}};
      end else begin
         fetched_q <= ptr_q;
         for (int s = 0; s < NUM_SEQ; s++) begin
            if (wr_acc && paddr_i == ADDR_SEQ_START) begin
               ptr_q[s] <= pwdata_i[s*CB_IDX_W +: CB_IDX_W];
            end else if (hit[s] && advancing(cb[s]) && cb[s].next_block != CB_NONE) begin
               ptr_q[s] <= cb[s].next_block;
            end else if (armed[s] && advancing(cb[s]) && word_valid_i && word_eom_i
                         && !hit[s] && cb[s].eom_block != CB_NONE) begin
               ptr_q[s] <= cb[s].eom_block;
            end
         end
      end
   end

   // ************************************************************************
   // Trigger actions
   // ************************************************************************
   always_comb begin
      clr_all = '0;
      set_all = '0;
      for (int s = 0; s < NUM_SEQ; s++) begin
         if (hit[s]) begin
            clr_all = clr_all | cb[s].status_clear_bits;
            set_all = set_all | cb[s].status_assert_bits;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status_q <= '0;
      end else if (|hit) begin
         status_q <= (status_q & ~clr_all) | set_all;
      end else if (wr_acc && paddr_i == ADDR_STATUS) begin
         status_q <= pwdata_i[STAT_W-1:0];
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         strobe_q <= 1'b0;
      end else begin
         strobe_q <= |(hit & {cb[1].strobe_on_fire, cb[0].strobe_on_fire});
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_q <= 1'b0;
         irq_num_q <= CB_NONE;
      end else begin
         irq_q <= 1'b0;
         if (hit[0] && cb[0].irq_on_fire) begin
            irq_q <= 1'b1;
            irq_num_q <= ptr_q[0];
         end else if (hit[1] && cb[1].irq_on_fire) begin
            irq_q <= 1'b1;
            irq_num_q <= ptr_q[1];
         end
      end
   end

   assign trig_strobe_o = strobe_q;
   assign cb_irq_o = irq_q;
   assign cb_irq_num_o = irq_num_q;
   assign status_pattern_o = status_q;

   // ************************************************************************
   // Checks
   // ************************************************************************
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   AST_STROBE: assert property (hit[0] && cb[0].strobe_on_fire |=> trig_strobe_o)
      else $error("strobe missing after fire");
   AST_IRQ_NUM: assert property (hit[0] && cb[0].irq_on_fire
      |=> cb_irq_o && cb_irq_num_o == $past(ptr_q[0]))
      else $error("interrupt or block number wrong");
   AST_NO_IRQ: assert property (!(hit[0] || hit[1]) |=> !cb_irq_o)
      else $error("interrupt without fire");
   AST_CLEAR: assert property (hit[0] |=>
      (status_pattern_o & $past(cb[0].status_clear_bits & ~set_all)) == '0)
      else $error("clear bits not cleared");
   AST_SET: assert property (hit[1] |=>
      (status_pattern_o & $past(cb[1].status_assert_bits)) == $past(cb[1].status_assert_bits))
      else $error("set bits not set");
   AST_ADVANCE: assert property (hit[0] && advancing(cb[0]) && cb[0].next_block != CB_NONE
      && !(wr_acc && paddr_i == ADDR_SEQ_START) |=> ptr_q[0] == $past(cb[0].next_block))
      else $error("sequence did not advance");
   AST_STATIC: assert property (hit[1] && !advancing(cb[1])
      && !(wr_acc && paddr_i == ADDR_SEQ_START) |=> $stable(ptr_q[1]))
      else $error("static trigger moved");
   AST_EXT: assert property ($rose(pin_sync_q[1]) && armed[0]
      && cb[0].trigger_kind == KIND_EXTERNAL |-> hit[0])
      else $error("external pulse missed");
   AST_SWX_RESET: assert property ($rose(rst_n_i) |-> swx_mask_q == SWX_MASK_RESET)
      else $error("exception mask reset value wrong");
   COV_BOTH: cover property (hit[0] && hit[1]);
   COV_CHAIN: cover property (hit[0] ##[1:20] hit[0]);
   COV_EOM: cover property (armed[0] && word_eom_i && !hit[0]);
endmodule : trig_unit

// [bus_traffic_model.sv]
// Far side model: decoded bus words, error events and trigger pin
`timescale 1ns/1ps
module bus_traffic_model
   import trig_pkg::*;
(
   // Clock
   input wire logic clk_sys_i,
   // Events and pin
   output logic word_valid_o,
   output logic [15:0] word_data_o,
   output logic word_is_status_o,
   output logic word_eom_o,
   output logic err_valid_o,
   output logic [ERR_ANY_FAULT-1:0] err_flags_o,
   output logic trig_pin_o
);
   initial begin
      word_valid_o = 1'b0;
      word_data_o = 16'h5A5A;
      word_is_status_o = 1'b0;
      word_eom_o = 1'b0;
      err_valid_o = 1'b0;
      err_flags_o = 15'h2AAA;
      trig_pin_o = 1'b0;
   end
   // Data is inverted once no longer valid
   task automatic send_word(input logic [15:0] d, input logic eom);
      word_valid_o <= 1'b1;
      word_data_o <= d;
      word_eom_o <= eom;
      @(posedge clk_sys_i);
      word_valid_o <= 1'b0;
      word_data_o <= ~d;
      word_eom_o <= ~eom;
   endtask : send_word
   task automatic send_status(input logic [15:0] d);
      word_is_status_o <= 1'b1;
      send_word(d, 1'b0);
      word_is_status_o <= 1'b0;
   endtask : send_status
   task automatic send_err(input logic [ERR_ANY_FAULT-1:0] f);
      err_valid_o <= 1'b1;
      err_flags_o <= f;
      @(posedge clk_sys_i);
      err_valid_o <= 1'b0;
      err_flags_o <= ~f;
   endtask : send_err
   task automatic pulse_pin;
      trig_pin_o <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      trig_pin_o <= 1'b0;
   endtask : pulse_pin
endmodule : bus_traffic_model

// [tb_top.sv]
// Self-checking bench of the trigger unit
`timescale 1ns/1ps
module tb_top;
   import trig_pkg::*;
   logic clk_sys_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic word_valid_i, word_is_status_i, word_eom_i, err_valid_i, trig_pin_i;
   logic trig_strobe_o, cb_irq_o;
   logic [7:0] paddr_i, cb_irq_num_o, status_pattern_o;
   logic [31:0] pwdata_i, prdata_o;
   logic [15:0] word_data_i;
   logic [ERR_ANY_FAULT-1:0] err_flags_i;
   int err_total = 0;
   int checks = 0;
   trig_unit DUT (.clk_sys_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .word_valid_i, .word_data_i, .word_is_status_i,
      .word_eom_i, .err_valid_i, .err_flags_i, .trig_pin_i, .trig_strobe_o, .cb_irq_o,
      .cb_irq_num_o, .status_pattern_o);
   bus_traffic_model P (.clk_sys_i, .word_valid_o(word_valid_i), .word_data_o(word_data_i),
      .word_is_status_o(word_is_status_i), .word_eom_o(word_eom_i),
      .err_valid_o(err_valid_i), .err_flags_o(err_flags_i), .trig_pin_o(trig_pin_i));
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   task automatic test_done;
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
         err_total++;
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (pready_o !== 1'b1 && n < 16);
      if (pready_o !== 1'b1) begin
         err_total++;
         test_done();
      end
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
   endtask : rd
   // Word 0: kind, {strobe, irq, flip}, clear, set
   function automatic logic [31:0] w0(input logic [1:0] k, input logic [2:0] f,
         input logic [7:0] c, input logic [7:0] s);
      return {11'h0, k, f, c, s};
   endfunction : w0
   task automatic load_cb(input logic [7:0] i, input logic [31:0] a, input logic [31:0] b,
         input logic [31:0] c, input logic [31:0] d);
      wr(ADDR_CB_W0, a);
      wr(ADDR_CB_W1, b);
      wr(ADDR_CB_W2, c);
      wr(ADDR_CB_W3, d);
      wr(ADDR_CB_COMMIT, {24'h0, i});
   endtask : load_cb
   task automatic arm(input logic [7:0] b0, input logic [7:0] b1, input logic [1:0] en);
      wr(ADDR_SEQ_START, {16'h0, b1, b0});
      wr(ADDR_CTRL, {30'h0, en});
      repeat (2) @(posedge clk_sys_i);
   endtask : arm
   task automatic act(input logic s, input logic i, input logic [7:0] n, input logic [7:0] st);
      #1;
      chk(trig_strobe_o, s);
      chk(cb_irq_o, i);
      if (i) chk(cb_irq_num_o, n);
      chk(status_pattern_o, st);
      @(posedge clk_sys_i);
   endtask : act
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_regs;
      logic [31:0] r;
      logic e;
      rd(ADDR_SWX_MASK, 32'h7FF);
      rd(ADDR_STATE, 32'hFFFFFF);
      apb(1'b0, 8'h40, 32'h0, r, e);
      chk(e, 1'b1);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_err;
      load_cb(8'd3, w0(KIND_ERROR, 3'b110, 8'h00, 8'h0F), 32'hFFFF, 32'h2010FFFF, 32'h0);
      arm(8'd3, 8'hFF, 2'b01);
      P.send_err(15'h0001 << ERR_FEW_WORDS);
      act(1'b1, 1'b1, 8'd3, 8'h0F);
      P.send_err(15'h0001 << ERR_EXTRA_WORDS);
      act(1'b0, 1'b0, 8'd3, 8'h0F);
      P.send_err(15'h0001 << ERR_ODD_EVEN_FAULT);
      act(1'b1, 1'b1, 8'd3, 8'h0F);
      rd(ADDR_STATE, 32'h03FF03);
      $display("t_err done");
   endtask : t_err
   task automatic t_bits;
      int b;
      load_cb(8'd5, w0(KIND_ERROR, 3'b010, 8'h0F, 8'h30), 32'hFFFF, 32'h8000FFFF, 32'h0);
      arm(8'd5, 8'hFF, 2'b01);
      P.send_err(15'h0001);
      act(1'b0, 1'b1, 8'd5, 8'h30);
      for (b = 0; b < 15; b++) begin
         load_cb(8'd6, w0(KIND_ERROR, 3'b010, 8'h00, 8'h00), 32'hFFFF,
            {16'h1 << b, 16'hFFFF}, 32'h0);
         arm(8'd6, 8'hFF, 2'b01);
         P.send_err(~(15'h0001 << b));
         act(1'b0, 1'b0, 8'd0, 8'h30);
         P.send_err(15'h0001 << b);
         act(1'b0, 1'b1, 8'd6, 8'h30);
      end
      $display("t_bits done");
   endtask : t_bits
   task automatic t_chain;
      load_cb(8'd10, w0(KIND_WORD, 3'b010, 8'h00, 8'h00), 32'h0BFF, 32'h01000100, 32'h0);
      load_cb(8'd11, w0(KIND_VALUE, 3'b100, 8'h00, 8'h80), 32'hFFFF, 32'h00FF, 32'h100020);
      arm(8'd10, 8'hFF, 2'b01);
      P.send_word(16'h0200, 1'b0);
      act(1'b0, 1'b0, 8'd0, 8'h30);
      P.send_word(16'hFF00, 1'b0);
      act(1'b0, 1'b1, 8'd10, 8'h30);
      repeat (3) @(posedge clk_sys_i);
      P.send_word(16'h7F20, 1'b0);
      act(1'b1, 1'b0, 8'd0, 8'hB0);
      P.send_word(16'h0021, 1'b0);
      act(1'b0, 1'b0, 8'd0, 8'hB0);
      rd(ADDR_STATE, 32'h0AFF0B);
      $display("t_chain done");
   endtask : t_chain
   task automatic t_flip;
      load_cb(8'd12, w0(KIND_VALUE, 3'b011, 8'h80, 8'h00), 32'hFF0C, 32'hFFFF, 32'h100020);
      load_cb(8'd13, w0(KIND_WORD, 3'b000, 8'h00, 8'h00), 32'hFF0E, 32'h1234FFFF, 32'h0);
      arm(8'd12, 8'd13, 2'b11);
      P.send_word(16'h0015, 1'b0);
      act(1'b0, 1'b0, 8'd0, 8'hB0);
      P.send_word(16'h0009, 1'b0);
      act(1'b0, 1'b1, 8'd12, 8'h30);
      P.send_word(16'h0015, 1'b1);
      act(1'b0, 1'b0, 8'd0, 8'h30);
      rd(ADDR_STATE, 32'h0C0E0C);
      $display("t_flip done");
   endtask : t_flip
   task automatic t_ext;
      int n;
      load_cb(8'd253, w0(KIND_EXTERNAL, 3'b100, 8'h00, 8'h01), 32'hFFFF, 32'hFFFFFFFF, 32'h0);
      arm(8'd253, 8'hFF, 2'b01);
      P.pulse_pin();
      n = 0;
      while (trig_strobe_o !== 1'b1 && n < 8) begin
         @(posedge clk_sys_i);
         n++;
      end
      chk(trig_strobe_o, 1'b1);
      if (n == 8) test_done();
      chk(status_pattern_o, 8'h31);
      arm(8'd3, 8'd5, 2'b11);
      P.send_err(15'h0001 << ERR_FEW_WORDS);
      act(1'b1, 1'b1, 8'd3, 8'h3F);
      $display("t_ext done");
   endtask : t_ext
   task automatic t_swx;
      wr(ADDR_SWX_MASK, 32'h4);
      rd(ADDR_SWX_MASK, 32'h4);
      wr(ADDR_STATUS, 32'h0);
      rd(ADDR_STATUS, 32'h0);
      load_cb(8'd7, w0(KIND_ERROR, 3'b010, 8'h00, 8'h40), 32'hFFFF, 32'h0800FFFF, 32'h0);
      arm(8'd7, 8'hFF, 2'b01);
      P.send_status(16'h0003);
      act(1'b0, 1'b0, 8'd0, 8'h00);
      P.send_status(16'h0004);
      act(1'b0, 1'b1, 8'd7, 8'h40);
      $display("t_swx done");
   endtask : t_swx
   initial begin
      rst_n_i = 1'b0;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 8'h00;
      pwdata_i = 32'h0;
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      t_regs();
      t_err();
      t_bits();
      t_chain();
      t_flip();
      t_ext();
      t_swx();
      test_done();
   end
endmodule : tb_top
